// ---- byte_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } fifo_state_t;

  fifo_state_t       st_q;
  fifo_state_t       st_d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full and empty come straight from the count, so they never lie.
  assign in_ready  = (st_q.count != (AW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data  = mem[st_q.rd_ptr];
  assign level     = st_q.count;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update.
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // The storage array carries no reset; only the pointers and the count need one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
    if (push) begin
      mem[st_q.wr_ptr] <= in_data;
    end
  end

endmodule // byte_fifo

`default_nettype wire

// ---- printer_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module printer_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       strobe_n,
  input wire logic       select_in_n,
  input wire logic [7:0] data,
  input wire logic       hold_busy,
  input wire logic       fault,
  input wire logic       no_paper,
  output logic           busy,
  output logic           ack_n,
  output logic           error_n,
  output logic           paper_out,
  output logic           printer_selected,
  output logic [7:0]     last_byte
);
  logic [3:0] cnt_q;
  logic       stb_q;
  // Status levels; the bench holds busy up to act as a slow printer.
  assign busy = hold_busy || (cnt_q != 4'h0);
  assign ack_n = (cnt_q != 4'h1);
  assign error_n = !fault;
  assign paper_out = no_paper;
  assign printer_selected = !select_in_n;
  // A falling strobe takes the byte, then busy runs out with an ack pulse.
  always @(posedge aclk) begin
    stb_q <= strobe_n;
    if (!aresetn) begin
      cnt_q <= 4'h0;
    end else if (stb_q && !strobe_n) begin
      cnt_q <= 4'h6;
      last_byte <= data;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // printer_model
`default_nettype wire

// ---- printer_port_pin_control.sv ----
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module printer_port_pin_control (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Printer side.
  output logic             print_strobe_n,
  output logic             print_strobe_oe_n,
  output logic             auto_linefeed_n,
  output logic             auto_linefeed_oe_n,
  output logic             init_n,
  output logic             init_oe_n,
  output logic             select_in_n,
  output logic             select_in_oe_n,
  input  wire logic [7:0]  printer_data_bus_i,
  output logic [7:0]       printer_data_bus_o,
  output logic             printer_data_bus_oe_n,
  input  wire logic        error_n,
  input  wire logic        paper_out,
  input  wire logic        printer_selected,
  input  wire logic        busy,
  input  wire logic        ack_n,
  // Host side lines.
  input  wire logic        epp_cycle,
  output logic             chan_ready_o,
  output logic             chan_ready_oe_n,
  output logic [15:0]      irq_o,
  output logic [15:0]      irq_oe_n,
  output logic [3:0]       drq_o,
  output logic [3:0]       drq_oe_n,
  input  wire logic        term_count
);

  typedef struct packed {
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [7:0]       ctrl;
    logic [2:0]       cfg;
    logic [3:0]       irq_sel;
    logic [1:0]       dma_sel;
    logic [7:0]       pins;
    logic             ack_prev;
    logic             irq_pend;
    logic             tc_seen;
    logic [7:0]       out_byte;
    logic             out_valid;
    logic [7:0]       epp_cnt;
  } state_t;

  state_t          st_q;
  state_t          st_d;
  logic            enabled;
  prn_pkg::mode_t  mode;
  logic            wr_go;
  logic            data_wr;
  logic            fifo_in_ready;
  logic [7:0]      fifo_out_data;
  logic            fifo_out_valid;
  logic            fifo_out_ready;
  logic [4:0]      fifo_level;
  logic            deliver;
  logic [31:0]     status_word;

  ////////////////////////////////////////////////////////////////////////////
  assign enabled = st_q.cfg[prn_pkg::CFG_ENABLE];
  assign mode    = prn_pkg::mode_t'(st_q.cfg[prn_pkg::CFG_MODE +: 2]);
  assign wr_go   = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
  // A data write is stalled while the FIFO is full, which holds the bus back.
  assign data_wr = wr_go & (st_q.aw_addr == prn_pkg::OFS_DATA) & enabled & st_q.w_strb[0];

  // The printer takes the next byte when it is not busy and no byte is waiting.
  assign deliver        = enabled & ~busy & ~st_q.out_valid;
  assign fifo_out_ready = deliver;

  // The FIFO lets the host run ahead of a slow printer by up to sixteen bytes.
  byte_fifo #(
    .WIDTH (prn_pkg::FIFO_WIDTH),
    .DEPTH (prn_pkg::FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (st_q.w_data[7:0]),
    .in_valid  (data_wr),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .level     (fifo_level)
  );

  // Inputs are gated off while disabled, so the pin status bits read as zero then; FIFO level and TC still show.
  always_comb begin
    status_word = '0;
    if (enabled) begin
      status_word[prn_pkg::STAT_ERROR]    = error_n;
      status_word[prn_pkg::STAT_SELECTED] = printer_selected;
      status_word[prn_pkg::STAT_PAPER]    = paper_out;
      status_word[prn_pkg::STAT_ACK]      = ack_n;
      status_word[prn_pkg::STAT_BUSY]    = busy;
    end
    status_word[prn_pkg::STAT_FIFO_CNT +: 5] = fifo_level;
    status_word[prn_pkg::STAT_TC]            = st_q.tc_seen;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, register file and printer-side state.
  always_comb begin
    st_d = st_q;
    // Address and data are latched independently, in either order.
    if (s_axi_awvalid && !st_q.aw_held) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_held) begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    // A write completes once both halves are held; a data write waits for FIFO room.
    if (wr_go && (st_q.aw_addr != prn_pkg::OFS_DATA || !enabled || fifo_in_ready)) begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = prn_pkg::RESP_OKAY;
      if (st_q.w_strb[0]) begin
        unique case (st_q.aw_addr)
          prn_pkg::OFS_DATA:   ;
          prn_pkg::OFS_STATUS: ;
          prn_pkg::OFS_CTRL:   st_d.ctrl    = st_q.w_data[7:0];
          prn_pkg::OFS_CONFIG: st_d.cfg     = st_q.w_data[2:0];
          prn_pkg::OFS_IRQSEL: st_d.irq_sel = st_q.w_data[3:0];
          prn_pkg::OFS_DMASEL: st_d.dma_sel = st_q.w_data[1:0];
          default:             st_d.bresp   = prn_pkg::RESP_SLVERR;
        endcase
      end
      // Any write to status clears the sticky terminal-count flag.
      if (st_q.aw_addr == prn_pkg::OFS_STATUS) begin
        st_d.tc_seen = 1'b0;
      end
    end
    // The response stands until the master takes it.
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = prn_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        prn_pkg::OFS_DATA:   st_d.rdata = {24'h000000, enabled ? printer_data_bus_i : 8'h00};
        prn_pkg::OFS_STATUS: st_d.rdata = status_word;
        prn_pkg::OFS_CTRL:   st_d.rdata = {24'h000000, st_q.ctrl};
        prn_pkg::OFS_CONFIG: st_d.rdata = {29'h0, st_q.cfg};
        prn_pkg::OFS_IRQSEL: st_d.rdata = {28'h0000000, st_q.irq_sel};
        prn_pkg::OFS_DMASEL: st_d.rdata = {30'h0, st_q.dma_sel};
        default: begin
          st_d.rdata = '0;
          st_d.rresp = prn_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Pins register the control bits, so they move one cycle after the write.
    st_d.pins = st_q.ctrl;
    // Logic freezes while disabled, standing in for the stopped clock.
    if (enabled) begin
      st_d.ack_prev = ack_n;
      // A status read clears the pending interrupt; it comes first so that an
      // acknowledge edge in the same cycle still leaves the interrupt pending.
      if (s_axi_arvalid && !st_q.rvalid && s_axi_araddr == prn_pkg::OFS_STATUS) begin
        st_d.irq_pend = 1'b0;
      end
      // A falling acknowledge frees the output byte for the next one.
      if (st_q.ack_prev && !ack_n) begin
        st_d.irq_pend = 1'b1;
        st_d.out_valid = 1'b0;
      end
      if (fifo_out_valid && deliver) begin
        st_d.out_byte  = fifo_out_data;
        st_d.out_valid = 1'b1;
      end
      // Terminal count is sticky; it wins over a status write in the same cycle.
      if (term_count) begin
        st_d.tc_seen = 1'b1;
      end
      // Stretch the host cycle while the printer is busy, up to a bound.
      if (epp_cycle && mode == prn_pkg::MODE_EPP && busy
          && st_q.epp_cnt != prn_pkg::EPP_WAIT_CYC) begin
        st_d.epp_cnt = st_q.epp_cnt + 8'h01;
      end else if (!epp_cycle) begin
        st_d.epp_cnt = 8'h00;
      end
    end
  end

  // Synchronous reset; registered fields start from their reset values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q          <= '0;
      st_q.ctrl     <= prn_pkg::CTRL_RESET;
      st_q.pins     <= prn_pkg::CTRL_RESET;
      st_q.cfg      <= prn_pkg::CFG_RESET;
      st_q.irq_sel  <= prn_pkg::IRQSEL_RESET;
      st_q.dma_sel  <= prn_pkg::DMASEL_RESET;
      st_q.ack_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes.
  assign s_axi_awready = ~st_q.aw_held;
  assign s_axi_wready  = ~st_q.w_held;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

  // Control pins come from registered bits only, so no decode glitch escapes.
  assign print_strobe_n     = ~st_q.pins[prn_pkg::CTRL_STROBE];
  assign auto_linefeed_n    = ~st_q.pins[prn_pkg::CTRL_AUTOLF];
  assign init_n             = st_q.pins[prn_pkg::CTRL_INIT];
  assign select_in_n        = ~st_q.pins[prn_pkg::CTRL_SELIN];
  assign print_strobe_oe_n  = ~enabled;
  assign auto_linefeed_oe_n = ~enabled;
  assign init_oe_n          = ~enabled;
  assign select_in_oe_n     = ~enabled;

  // Data floats when disabled, deselected, or turned round for input.
  assign printer_data_bus_o    = st_q.out_byte;
  assign printer_data_bus_oe_n = ~enabled | ~st_q.pins[prn_pkg::CTRL_SELIN]
                                 | (st_q.pins[prn_pkg::CTRL_DIR] & mode != prn_pkg::MODE_SPP);

  // Open-drain channel ready: pulled low while the stretch runs.
  assign chan_ready_o    = 1'b0;
  assign chan_ready_oe_n = ~(enabled & epp_cycle & mode == prn_pkg::MODE_EPP & busy
                             & st_q.epp_cnt != prn_pkg::EPP_WAIT_CYC);

  // Only the selected request line is driven; the rest float.
  always_comb begin
    irq_o    = '0;
    irq_oe_n = '1;
    drq_o    = '0;
    drq_oe_n = '1;
    if (enabled) begin
      irq_o[st_q.irq_sel]    = st_q.irq_pend;
      irq_oe_n[st_q.irq_sel] = 1'b0;
      drq_o[st_q.dma_sel]    = fifo_in_ready & (mode == prn_pkg::MODE_ECP) & ~st_q.tc_seen;
      drq_oe_n[st_q.dma_sel] = 1'b0;
    end
  end

endmodule // printer_port_pin_control

`default_nettype wire

// ---- prn_pkg.sv ----
package prn_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_IRQSEL = 8'h10;
  localparam logic [7:0] OFS_DMASEL = 8'h14;

  // Control register field positions.
  localparam int CTRL_STROBE   = 0;
  localparam int CTRL_AUTOLF   = 1;
  localparam int CTRL_INIT     = 2;
  localparam int CTRL_SELIN    = 3;
  localparam int CTRL_DIR      = 5;

  // Status register field positions.
  localparam int STAT_ERROR    = 3;
  localparam int STAT_SELECTED = 4;
  localparam int STAT_PAPER    = 5;
  localparam int STAT_ACK      = 6;
  localparam int STAT_BUSY     = 7;
  localparam int STAT_FIFO_CNT = 8;
  localparam int STAT_TC       = 13;

  // Config register field positions.
  localparam int CFG_ENABLE    = 0;
  localparam int CFG_MODE      = 1;

  // Reset values.
  localparam logic [7:0] CTRL_RESET   = 8'h04;
  localparam logic [2:0] CFG_RESET    = 3'h0;
  localparam logic [3:0] IRQSEL_RESET = 4'h7;
  localparam logic [1:0] DMASEL_RESET = 2'h3;

  // Port modes.
  typedef enum logic [1:0] {
    MODE_SPP = 2'b00,
    MODE_BIDIR = 2'b01,
    MODE_EPP = 2'b10,
    MODE_ECP = 2'b11
  } mode_t;

  // Bus answer codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Data FIFO shape and EPP wait bound.
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int EPP_WAIT_NS = 10000;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [7:0] EPP_WAIT_CYC = 8'(EPP_WAIT_NS / CLK_PERIOD_NS);

endpackage

// ---- prn_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module prn_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        print_strobe_n,
  input wire logic        print_strobe_oe_n,
  input wire logic        auto_linefeed_oe_n,
  input wire logic        init_oe_n,
  input wire logic        select_in_n,
  input wire logic        select_in_oe_n,
  input wire logic        printer_data_bus_oe_n,
  input wire logic        epp_cycle,
  input wire logic        busy,
  input wire logic        chan_ready_o,
  input wire logic        chan_ready_oe_n,
  input wire logic [15:0] irq_oe_n,
  input wire logic [3:0]  drq_oe_n
);
  logic [8:0] wait_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Length of the current stretch; a stuck wait would hang the host bus.
  always_ff @(posedge aclk) begin
    if (!aresetn || chan_ready_oe_n) begin
      wait_q <= 9'h000;
    end else begin
      wait_q <= wait_q + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Checks on the printer pins, host lines and register bus handshakes.
  oe_group_a: assert property (
    print_strobe_oe_n == auto_linefeed_oe_n && init_oe_n == select_in_oe_n && print_strobe_oe_n == init_oe_n)
    else $error("control enables differ");
  off_float_a: assert property (print_strobe_oe_n |->
    printer_data_bus_oe_n && chan_ready_oe_n && (&irq_oe_n) && (&drq_oe_n)) else $error("disabled port drives");
  bus_float_a: assert property (select_in_n && $past(select_in_n) |-> printer_data_bus_oe_n)
    else $error("data bus driven while deselected");
  chan_low_a: assert property (chan_ready_o == 1'b0) else $error("channel ready driven high");
  chan_wait_a: assert property (!chan_ready_oe_n |->
    (epp_cycle || $past(epp_cycle)) && (busy || $past(busy))) else $error("stretch without cause");
  chan_bound_a: assert property (wait_q <= 9'h0FB) else $error("stretch too long");
  irq_one_a: assert property ($countones(~irq_oe_n) <= 1) else $error("several irq lines");
  drq_one_a: assert property ($countones(~drq_oe_n) <= 1) else $error("several drq lines");
  pins_write_a: assert property ($changed(print_strobe_n) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("strobe moved without a write");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  c_stretch: cover property (!chan_ready_oe_n);
  c_drive: cover property (!printer_data_bus_oe_n);
  c_strobe: cover property ($fell(print_strobe_n));
endmodule // prn_sva
bind printer_port_pin_control prn_sva i_prn_sva (.*);
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, epp_cycle;
  logic        print_strobe_n, print_strobe_oe_n, auto_linefeed_n, auto_linefeed_oe_n, init_n, init_oe_n;
  logic        select_in_n, select_in_oe_n, printer_data_bus_oe_n, chan_ready_o, chan_ready_oe_n;
  logic        error_n, paper_out, printer_selected, busy, ack_n, term_count, hold_busy, fault, no_paper;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, printer_data_bus_i, printer_data_bus_o, last_byte, pat_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, drq_o, drq_oe_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] irq_o, irq_oe_n;
  int          bad_count, check_count, k, n;
  printer_port_pin_control i_printer_port_pin_control (.*);
  printer_model i_printer_model (.aclk(aclk), .aresetn(aresetn), .data(printer_data_bus_i),
    .strobe_n(print_strobe_oe_n ? 1'b1 : print_strobe_n), .select_in_n(select_in_oe_n ? 1'b1 : select_in_n),
    .hold_busy(hold_busy), .fault(fault), .no_paper(no_paper), .busy(busy), .ack_n(ack_n),
    .error_n(error_n), .paper_out(paper_out), .printer_selected(printer_selected), .last_byte(last_byte));
  ////////////////////////////////////////////////////////////////
  // A floating data bus shows a moving pattern, so stale values never pass.
  assign printer_data_bus_i = printer_data_bus_oe_n ? pat_q : printer_data_bus_o;
  always @(posedge aclk) pat_q <= pat_q + 8'h01;
  // Clock at 25 MHz.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic s);
    chk(nm, 32'(e), 32'(s));
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask
  // A lost answer would hang the run, so each bus task's wait gives up after 300 cycles.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 300 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (n == 300) chk("write answer", 1, 0);
    if (n == 300) test_done();
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 300 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n == 300) chk("read answer", 1, 0);
    if (n == 300) test_done();
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence; waits of fixed length let reset, the pins and the printer model settle.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, epp_cycle} = 6'h00;
    {aresetn, term_count, hold_busy, fault, no_paper, bad_count, check_count, pat_q} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    tick(12);
    aresetn <= 1'b1;
    rdt(prn_pkg::OFS_CTRL); chk("ctrl reset", 32'(prn_pkg::CTRL_RESET), rd);
    rdt(prn_pkg::OFS_CONFIG); chk("cfg reset", 32'(prn_pkg::CFG_RESET), rd);
    rdt(prn_pkg::OFS_IRQSEL); chk("irq sel reset", 32'(prn_pkg::IRQSEL_RESET), rd);
    rdt(prn_pkg::OFS_DMASEL); chk("dma sel reset", 32'(prn_pkg::DMASEL_RESET), rd);
    chb("strobe reset", 1, print_strobe_n & print_strobe_oe_n);
    rdt(8'h18); chk("unmapped read", 0, rd); chk("unmapped rresp", 32'(prn_pkg::RESP_SLVERR), 32'(rsp));
    wr(8'h18, 32'h1); chk("unmapped bresp", 32'(prn_pkg::RESP_SLVERR), 32'(rsp));
    wr(prn_pkg::OFS_CONFIG, 32'h1);
    for (k = 0; k < 16; k++) begin
      wr(prn_pkg::OFS_CTRL, 32'(k));
      tick(2);
      chb("strobe", ~k[0], print_strobe_n);
      chb("linefeed", ~k[1], auto_linefeed_n);
      chb("init", k[2], init_n);
      chb("select in", ~k[3], select_in_n);
      chb("data float", ~k[3], printer_data_bus_oe_n);
    end
    wr(prn_pkg::OFS_CTRL, 32'h8);
    fault <= 1'b1;
    no_paper <= 1'b1;
    tick(10);
    rdt(prn_pkg::OFS_STATUS); chk("status", 32'h0E, 32'(rd[7:3]));
    fault <= 1'b0;
    hold_busy <= 1'b1;
    tick(2);
    rdt(prn_pkg::OFS_STATUS); chk("status busy", 32'h1F, 32'(rd[7:3]));
    hold_busy <= 1'b0;
    for (k = 0; k < 16; k += 5) begin
      wr(prn_pkg::OFS_IRQSEL, 32'(k));
      wr(prn_pkg::OFS_CTRL, 32'h9);
      wr(prn_pkg::OFS_CTRL, 32'h8);
      tick(10);
      chk("irq enable", {16'h0000, ~(16'h0001 << k)}, 32'(irq_oe_n));
      chb("irq level", 1, irq_o[k]);
      rdt(prn_pkg::OFS_STATUS);
      tick(2);
      chb("irq clear", 0, irq_o[k]);
    end
    wr(prn_pkg::OFS_CONFIG, 32'h7);
    hold_busy <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr(prn_pkg::OFS_DMASEL, 32'(k));
      tick(2);
      chk("drq enable", {28'h0000000, ~(4'h1 << k)}, 32'(drq_oe_n));
      chb("drq level", 1, drq_o[k]);
    end
    for (k = 0; k < 16; k++) wr(prn_pkg::OFS_DATA, 32'h A0 + 32'(k));
    rdt(prn_pkg::OFS_STATUS); chk("fifo full", 32'h10, 32'(rd[12:8]));
    chb("drq when full", 0, drq_o[3]);
    hold_busy <= 1'b0;
    tick(4);
    for (k = 0; k < 16; k++) begin
      wr(prn_pkg::OFS_CTRL, 32'h9);
      wr(prn_pkg::OFS_CTRL, 32'h8);
      tick(10);
      chk("byte order", 32'h A0 + 32'(k), 32'(last_byte));
    end
    rdt(prn_pkg::OFS_STATUS); chk("fifo empty", 0, 32'(rd[12:8]));
    rdt(prn_pkg::OFS_DATA); chk("data readback", 32'hAF, rd);
    term_count <= 1'b1;
    tick(1);
    term_count <= 1'b0;
    tick(2);
    chb("drq after tc", 0, drq_o[3]);
    rdt(prn_pkg::OFS_STATUS); chb("tc set", 1, rd[13]);
    wr(prn_pkg::OFS_STATUS, 32'h0);
    rdt(prn_pkg::OFS_STATUS); chb("tc clear", 0, rd[13]);
    wr(prn_pkg::OFS_CONFIG, 32'h3);
    wr(prn_pkg::OFS_CTRL, 32'h28);
    tick(2);
    chb("reverse float", 1, printer_data_bus_oe_n);
    wr(prn_pkg::OFS_CONFIG, 32'h5);
    hold_busy <= 1'b1;
    epp_cycle <= 1'b1;
    tick(3);
    chb("epp stretch", 0, chan_ready_oe_n | chan_ready_o);
    hold_busy <= 1'b0;
    tick(3);
    chb("epp release", 1, chan_ready_oe_n);
    epp_cycle <= 1'b0;
    hold_busy <= 1'b1;
    tick(2);
    epp_cycle <= 1'b1;
    tick(3);
    for (k = 0; k < 400 && chan_ready_oe_n !== 1'b1; k++) @(posedge aclk);
    chb("epp bound", 1, k > 240 && k < 252);
    epp_cycle <= 1'b0;
    wr(prn_pkg::OFS_CONFIG, 32'h0);
    fault <= 1'b1;
    tick(2);
    chb("all off", 1, print_strobe_oe_n & printer_data_bus_oe_n & chan_ready_oe_n & (&irq_oe_n) & (&drq_oe_n));
    rdt(prn_pkg::OFS_STATUS); chk("inputs gated", 0, 32'(rd[7:3]));
    test_done();
  end
endmodule // testbench
`default_nettype wire
